//--- core/ecp_cam_profiler.sv
`timescale 1ns/1ns
`include "ecp_defs.svh"
// Notes on behaviour
// - Output between table points is linearly interpolated from the two neighbours.
// - While disabled, the master input is passed unchanged to the output.
// - Only a rising start edge begins a run; a held level does nothing.
// - Continuous: after start falls, run until input reaches table maximum, then stop.
// - Single shot: the run ends the first time input reaches the maximum.
// - A preset command loads the output register with the preset value.
// - Relative mode: start initialises the base to the measured position.
// - Each table's maximum input gets its own offset, rescaling the profile.
// - Mode bits come from the stored table, beside its points.
// - Relative mode: table output is added to the previous end position.
// - Absolute mode: accumulated follower position is cleared at each start.
// - Single shot: one pass per start, then hold the end position.
// - Continuous: repeat the table while enable and start stay active.
// - Auto-increment continuous: next table at end, last wraps to first.
// - Auto-increment single shot: hold, then next start runs next table.
// - Auto-increment, negative input: previous table, first wraps to last.
// - Without auto-increment the table stays unchanged at the end.
// - Table contents are not validated; loader owns correctness.
module ecp_cam_profiler #(
    parameter int TABS = 4,
    parameter int NPTS = 16,
    parameter int CYC_CLKS = `ECP_CYC_CLKS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [11:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [11:0] i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Position chain
    input wire logic [31:0] i_master_pos,
    input wire logic [31:0] i_measured_position,
    output logic [31:0] o_follower_pos,
    output logic o_running,
    output logic [$clog2(TABS)-1:0] o_active_table
);
    localparam int TW = $clog2(TABS);
    localparam int IW = $clog2(NPTS);
    localparam int MW = TW + `ECP_TAB_SH;
    localparam int FR = `ECP_FRAC;
    localparam int NUM_W = 36 + FR;
    localparam logic [11:0] TAB_BYTES = 12'(TABS << (`ECP_TAB_SH + 2));

    // AXI state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got, nxt_rvalid, do_wr;
    logic [1:0] bresp_ff, rresp_ff;
    logic [11:0] awaddr_ff, tab_woff, rd_addr, rd_off;
    logic [31:0] wdata_ff, rdata_ff, rd_val;
    logic [3:0] wstrb_ff;
    logic tab_whit, wr_hit, rd_hit;
    // Configuration and table store
    logic [31:0] ctrl_ff, preset_val_ff;
    logic [31:0] offs_ff [TABS];
    logic [31:0] mem [TABS << `ECP_TAB_SH];
    logic preset_req_ff, enable, start;
    logic [TW-1:0] sel;
    // Control cycle and run state
    logic [$clog2(CYC_CLKS)-1:0] cyc_cnt_ff;
    logic tick_ff, launch_ff, run_ff, done_ff, start_prev_ff;
    logic [TW-1:0] tab_ff, tab_up, tab_dn, st_tab;
    logic signed [31:0] org_ff, base_ff, x_ff, x_rel, max_eff, prev_max, end_val;
    logic [31:0] mode_w, st_mode;
    logic [MW-1:0] tb;
    // Interpolation engine
    ecp_pkg::ecp_calc_e calc_ff;
    logic [5:0] step_ff;
    logic [32:0] rem_ff, trial;
    logic [NUM_W-1:0] quo_ff;
    logic [35:0] num;
    logic sat;
    logic [IW-1:0] idx;
    logic [FR-1:0] frac;
    logic signed [31:0] p0, p1, p0_ff, out_ff;
    logic signed [49:0] prod_ff;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Write decode; read-only words accept and drop writes
    assign tab_woff = awaddr_ff - `ECP_A_TAB;
    assign tab_whit = (awaddr_ff >= `ECP_A_TAB) && (tab_woff < TAB_BYTES);
    assign wr_hit = tab_whit || (awaddr_ff < `ECP_A_OFFS + 12'(TABS * 4));
    assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;

    // Address and data may arrive in either order
    always_comb begin
        nxt_aw_got = (aw_got_ff && !do_wr) || (i_awvalid && awready_ff);
        nxt_w_got = (w_got_ff && !do_wr) || (i_wvalid && wready_ff);
        nxt_rvalid = (rvalid_ff && !i_rready) || (i_arvalid && arready_ff);
    end

    // Write channel handshakes and response
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `ECP_RESP_OK;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awready_ff <= !nxt_aw_got;
            wready_ff <= !nxt_w_got;
            if (i_awvalid && awready_ff) begin
                awaddr_ff <= {i_awaddr[11:2], 2'h0};
            end
            if (i_wvalid && wready_ff) begin
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (do_wr) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `ECP_RESP_OK : `ECP_RESP_DEC;
            end else if (i_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Software control, preset value and per-table offsets
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_ff <= 32'h0000_0000;
            preset_val_ff <= 32'h0000_0000;
            preset_req_ff <= 1'b0;
            for (int t = 0; t < TABS; t++) begin
                offs_ff[t] <= 32'h0000_0000;
            end
        end else begin
            preset_req_ff <= 1'b0;
            if (do_wr && awaddr_ff == `ECP_A_CTRL) begin
                ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
                preset_req_ff <= wstrb_ff[0] && wdata_ff[`ECP_B_PRESET];
            end
            if (do_wr && awaddr_ff == `ECP_A_PRESET) begin
                preset_val_ff <= merge(preset_val_ff, wdata_ff, wstrb_ff);
            end
            for (int t = 0; t < TABS; t++) begin
                if (do_wr && awaddr_ff == `ECP_A_OFFS + 12'(t * 4)) begin
                    offs_ff[t] <= merge(offs_ff[t], wdata_ff, wstrb_ff);
                end
            end
        end
    end

    assign enable = ctrl_ff[`ECP_B_EN];
    assign start = ctrl_ff[`ECP_B_START];
    assign sel = ctrl_ff[`ECP_B_SEL +: TW];

    // Table store; contents unchecked
    always_ff @(posedge i_mclk) begin
        if (do_wr && tab_whit) begin
            mem[tab_woff[MW+1:2]] <= merge(mem[tab_woff[MW+1:2]], wdata_ff, wstrb_ff);
        end
    end

    // Read decode
    always_comb begin
        rd_addr = {i_araddr[11:2], 2'h0};
        rd_off = rd_addr - `ECP_A_TAB;
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (rd_addr >= `ECP_A_TAB && rd_off < TAB_BYTES) begin
            rd_val = mem[rd_off[MW+1:2]];
        end else if (rd_addr >= `ECP_A_OFFS && rd_addr < `ECP_A_OFFS + 12'(TABS * 4)) begin
            rd_val = offs_ff[rd_addr[TW+1:2]];
        end else begin
            case (rd_addr)
                `ECP_A_CTRL: begin
                    rd_val = ctrl_ff & ~(32'h0000_0001 << `ECP_B_PRESET);
                end
                `ECP_A_PRESET: begin
                    rd_val = preset_val_ff;
                end
                `ECP_A_STATUS: begin
                    rd_val[`ECP_S_RUN] = run_ff;
                    rd_val[`ECP_S_DONE] = done_ff;
                    rd_val[`ECP_S_TAB +: TW] = tab_ff;
                end
                `ECP_A_OUT: begin
                    rd_val = out_ff;
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    // Read channel
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `ECP_RESP_OK;
        end else begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= !nxt_rvalid;
            if (i_arvalid && arready_ff) begin
                rdata_ff <= rd_val;
                rresp_ff <= rd_hit ? `ECP_RESP_OK : `ECP_RESP_DEC;
            end
        end
    end

    // Control cycle enable pulse
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cyc_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (cyc_cnt_ff == ($clog2(CYC_CLKS))'(CYC_CLKS - 1));
            if (cyc_cnt_ff == ($clog2(CYC_CLKS))'(CYC_CLKS - 1)) begin
                cyc_cnt_ff <= '0;
            end else begin
                cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
            end
        end
    end

    // Active table, adjusted maximum, neighbours
    always_comb begin
        tb = {tab_ff, `ECP_W_MAX};
        tab_up = (tab_ff == TW'(TABS - 1)) ? '0 : tab_ff + 1'b1;
        tab_dn = (tab_ff == '0) ? TW'(TABS - 1) : tab_ff - 1'b1;
        mode_w = mem[tb + MW'(`ECP_W_MODE)];
        max_eff = $signed(mem[tb]) + $signed(offs_ff[tab_ff]);
        prev_max = $signed(mem[{tab_dn, `ECP_W_MAX}]) + $signed(offs_ff[tab_dn]);
        end_val = $signed(mem[tb + MW'(`ECP_W_PT0) + MW'(NPTS - 1)]);
        x_rel = $signed(i_master_pos) - org_ff;
        st_tab = sel;
        if (mode_w[`ECP_M_AUTO] && !mode_w[`ECP_M_CONT] && done_ff) begin
            st_tab = tab_up;
        end
        st_mode = mem[{st_tab, `ECP_W_MODE}];
    end

    // Run sequencing, once per control cycle
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            run_ff <= 1'b0;
            done_ff <= 1'b0;
            start_prev_ff <= 1'b0;
            launch_ff <= 1'b0;
            tab_ff <= '0;
            org_ff <= 32'sh0000_0000;
            base_ff <= 32'sh0000_0000;
            x_ff <= 32'sh0000_0000;
        end else begin
            launch_ff <= 1'b0;
            if (tick_ff) begin
                start_prev_ff <= start;
                if (!enable) begin
                    run_ff <= 1'b0;
                end else if (start && !start_prev_ff) begin
                    run_ff <= 1'b1;
                    done_ff <= 1'b0;
                    launch_ff <= 1'b1;
                    tab_ff <= st_tab;
                    org_ff <= $signed(i_master_pos);
                    x_ff <= 32'sh0000_0000;
                    base_ff <= st_mode[`ECP_M_REL] ? $signed(i_measured_position)
                                                   : 32'sh0000_0000;
                end else if (run_ff) begin
                    launch_ff <= 1'b1;
                    if (x_rel >= max_eff) begin
                        if (mode_w[`ECP_M_CONT] && start) begin
                            org_ff <= org_ff + max_eff;
                            x_ff <= x_rel - max_eff;
                            if (mode_w[`ECP_M_REL]) begin
                                base_ff <= base_ff + end_val;
                            end
                            if (mode_w[`ECP_M_AUTO]) begin
                                tab_ff <= tab_up;
                            end
                        end else begin
                            run_ff <= 1'b0;
                            done_ff <= 1'b1;
                            x_ff <= max_eff;
                        end
                    end else if (x_rel < 0 && mode_w[`ECP_M_AUTO]) begin
                        tab_ff <= tab_dn;
                        org_ff <= org_ff - prev_max;
                        x_ff <= x_rel + prev_max;
                    end else begin
                        x_ff <= (x_rel < 0) ? 32'sh0000_0000 : x_rel;
                    end
                end
            end
        end
    end

    // Segment pick; bad maximum saturates to the last point
    always_comb begin
        num = 36'(x_ff[30:0]) * 36'(NPTS - 1);
        trial = {rem_ff[31:0], quo_ff[NUM_W-1]};
        sat = (|quo_ff[NUM_W-1:FR+IW]) || (quo_ff[FR +: IW] >= IW'(NPTS - 1));
        idx = sat ? IW'(NPTS - 1) : quo_ff[FR +: IW];
        frac = sat ? '0 : quo_ff[FR-1:0];
        p0 = $signed(mem[tb + MW'(`ECP_W_PT0) + MW'(idx)]);
        p1 = sat ? p0 : $signed(mem[tb + MW'(`ECP_W_PT0) + MW'(idx) + 1'b1]);
    end

    // Interpolation engine and output register
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            calc_ff <= ecp_pkg::CALC_IDLE;
            step_ff <= 6'h00;
            rem_ff <= 33'h0_0000_0000;
            quo_ff <= '0;
            p0_ff <= 32'sh0000_0000;
            prod_ff <= '0;
            out_ff <= 32'sh0000_0000;
        end else begin
            case (calc_ff)
                ecp_pkg::CALC_IDLE: begin
                    if (launch_ff) begin
                        rem_ff <= 33'h0_0000_0000;
                        quo_ff <= {num, {FR{1'b0}}};
                        step_ff <= 6'h00;
                        calc_ff <= ecp_pkg::CALC_DIV;
                    end
                end
                ecp_pkg::CALC_DIV: begin
                    // Restoring division: position over segment width
                    if (trial >= {1'b0, max_eff}) begin
                        rem_ff <= trial - {1'b0, max_eff};
                        quo_ff <= {quo_ff[NUM_W-2:0], 1'b1};
                    end else begin
                        rem_ff <= trial;
                        quo_ff <= {quo_ff[NUM_W-2:0], 1'b0};
                    end
                    step_ff <= step_ff + 1'b1;
                    if (step_ff == 6'(NUM_W - 1)) begin
                        calc_ff <= ecp_pkg::CALC_MUL;
                    end
                end
                ecp_pkg::CALC_MUL: begin
                    p0_ff <= p0;
                    prod_ff <= 50'($signed({p1[31], p1} - {p0[31], p0}) * $signed({1'b0, frac}));
                    calc_ff <= ecp_pkg::CALC_OUT;
                end
                ecp_pkg::CALC_OUT: begin
                    calc_ff <= ecp_pkg::CALC_IDLE;
                end
                default: begin
                    calc_ff <= ecp_pkg::CALC_IDLE;
                end
            endcase
            // Preset wins so software sees its value
            if (preset_req_ff) begin
                out_ff <= $signed(preset_val_ff);
            end else if (tick_ff && !enable) begin
                out_ff <= $signed(i_master_pos);
            end else if (calc_ff == ecp_pkg::CALC_OUT) begin
                out_ff <= base_ff + p0_ff + 32'(prod_ff >>> FR);
            end
        end
    end

    // Ports straight from flip-flops
    assign o_awready = awready_ff;
    assign o_wready = wready_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;
    assign o_follower_pos = out_ff;
    assign o_running = run_ff;
    assign o_active_table = tab_ff;
endmodule // ecp_cam_profiler

//--- inc/ecp_defs.svh
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH
// Register byte offsets
`define ECP_A_CTRL 12'h000
`define ECP_A_PRESET 12'h004
`define ECP_A_STATUS 12'h008
`define ECP_A_OUT 12'h00C
`define ECP_A_OFFS 12'h010
`define ECP_A_TAB 12'h100
// Control register fields
`define ECP_B_EN 0
`define ECP_B_START 1
`define ECP_B_PRESET 2
`define ECP_B_SEL 4
// Status register fields
`define ECP_S_RUN 0
`define ECP_S_DONE 1
`define ECP_S_TAB 4
// Table layout: log2 of words per table, word offsets
`define ECP_TAB_SH 5
`define ECP_W_MAX 5'h00
`define ECP_W_MODE 5'h01
`define ECP_W_PT0 5'h02
// Mode word bits
`define ECP_M_REL 0
`define ECP_M_CONT 1
`define ECP_M_AUTO 2
// Fraction bits of the interpolation weight
`define ECP_FRAC 16
// Control cycle timing
`define ECP_CLK_NS 10
`define ECP_CYC_NS 1000
`define ECP_CYC_CLKS (`ECP_CYC_NS / `ECP_CLK_NS)
// AXI responses
`define ECP_RESP_OK 2'h0
`define ECP_RESP_DEC 2'h3
`endif

//--- inc/ecp_pkg.sv
package ecp_pkg;
    // Interpolation engine states, Gray along the path
    typedef enum logic [1:0] {
        CALC_IDLE = 2'h0,
        CALC_DIV = 2'h1,
        CALC_MUL = 2'h3,
        CALC_OUT = 2'h2
    } ecp_calc_e;
endpackage

//--- testbench/ecp_cam_checker.sv
`timescale 1ns/1ns
`include "ecp_defs.svh"
module ecp_cam_checker (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Write channels
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    // Read channels
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [11:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    // Position outputs
    input wire logic [31:0] o_follower_pos,
    input wire logic o_running
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    // Write: both taken, gap, answer
    sequence wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence wr_answer;
        !o_bvalid ##1 o_bvalid;
    endsequence

    wr_lat_a: assert property (wr_taken |=> wr_answer)
        else $error("write answer late");
    wr_busy_a: assert property (wr_taken |=> !o_awready && !o_wready)
        else $error("write ready stuck");
    // Ready back with the answer, else writes stall
    wr_ready_a: assert property ($rose(o_bvalid) |-> o_awready && o_wready)
        else $error("write ready late");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write answer dropped");
    b_drop_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("bvalid stuck");
    rd_lat_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("read answer late");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read answer changed");
    r_drop_a: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
        else $error("rvalid stuck");
    // Hole below the tables is unmapped
    rd_decerr_a: assert property (i_arvalid && o_arready && i_araddr inside {[12'h020:12'h0FF]}
        |=> o_rresp == `ECP_RESP_DEC && o_rdata == 32'h0000_0000)
        else $error("bad read accepted");
    rst_out_a: assert property ($rose(i_resetn) |-> o_follower_pos == 32'h0000_0000 && !o_running)
        else $error("reset outputs");
endmodule // ecp_cam_checker

bind ecp_cam_profiler ecp_cam_checker ecp_cam_checker_inst (.i_mclk, .i_resetn, .i_awvalid,
    .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_follower_pos, .o_running);

//--- testbench/ecp_cam_profiler_bench.sv
`timescale 1ns/1ns
`include "ecp_defs.svh"
module ecp_cam_profiler_bench;
    localparam int CYC = 60;
    localparam int MAXIN = 960;
    localparam int STEP = 100;
    logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rd, base, v;
    logic [3:0] wstrb;
    logic [1:0] resp, bresp, rresp, atab;
    logic awready, wready, bvalid, arready, rvalid, running;
    logic [31:0] rdata, fpos, mpos, meas;
    int mismatches, checks, cyc, k;

    ecp_cam_profiler #(.CYC_CLKS(CYC)) ecp_cam_profiler_inst (.i_mclk(mclk), .i_resetn(resetn),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
        .o_arready(arready), .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rvalid),
        .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_master_pos(mpos),
        .i_measured_position(meas), .o_follower_pos(fpos), .o_running(running),
        .o_active_table(atab));
    ecp_pos_chain ecp_pos_chain_inst (.i_mclk(mclk), .i_follower_pos(fpos),
        .o_master_pos(mpos), .o_measured_position(meas));

    // Free running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, well above the run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end

    task automatic cmpv(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cmpr(input logic [1:0] got, input logic [1:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s resp %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Write: AW and W together, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic axr(input logic [11:0] a);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic ctl(input logic en, input logic st, input logic [1:0] s);
        axw(`ECP_A_CTRL, {26'h000_0000, s, 2'h0, st, en});
    endtask
    // Linear table, points STEP apart
    task automatic ld(input logic [1:0] t, input logic [31:0] m);
        logic [11:0] b;
        b = `ECP_A_TAB + {3'h0, t, 7'h00};
        axw(b, 32'(MAXIN));
        axw(b + 12'h004, m);
        for (int i = 0; i < 16; i++) axw(b + 12'h008 + 12'(4 * i), 32'(STEP * i));
    endtask
    // Start low for a tick, then high: a clean edge
    task automatic run(input logic [1:0] s);
        base = $urandom_range(1000000, 4000);
        ecp_pos_chain_inst.set_master(base);
        ctl(1'b1, 1'b0, s);
        wc(CYC + 4);
        ctl(1'b1, 1'b1, s);
        wc(2 * CYC);
    endtask
    task automatic mv(input int dx);
        ecp_pos_chain_inst.set_master(base + 32'(dx));
        wc(3 * CYC);
    endtask
    function automatic logic [31:0] cam(input int x, input int off);
        return 32'(x * STEP * 15 / (MAXIN + off));
    endfunction

    initial begin
        resetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        void'($urandom(32'hff72972d));
        wc(8);
        resetn <= 1'b1;
        wc(2);
        cmpv(fpos, 32'h0000_0000, "reset output");
        // Registers: refusals, read-only, preset
        axw(12'h020, 32'h0000_0001);
        cmpr(resp, `ECP_RESP_DEC, "bad write");
        axr(12'h020);
        cmpr(resp, `ECP_RESP_DEC, "bad read");
        cmpv(rd, 32'h0000_0000, "bad data");
        axw(`ECP_A_STATUS, 32'hffff_ffff);
        cmpr(resp, `ECP_RESP_OK, "status write");
        v = $urandom;
        axw(`ECP_A_PRESET, v);
        axw(`ECP_A_CTRL, 32'h0000_0005);
        wc(2);
        cmpv(fpos, v, "preset output");
        axr(`ECP_A_CTRL);
        cmpv(rd, 32'h0000_0001, "preset clears");
        wc(3 * CYC);
        cmpv(fpos, v, "preset held");
        $display("registers done");
        // Bypass, random master
        ctl(1'b0, 1'b0, 2'h0);
        repeat (4) begin
            v = $urandom;
            ecp_pos_chain_inst.set_master(v);
            wc(2 * CYC + 2);
            cmpv(fpos, v, "bypass");
            axr(`ECP_A_OUT);
            cmpv(rd, v, "out register");
        end
        $display("bypass done");
        ld(2'h0, 32'h0000_0000);
        ld(2'h1, 32'(1 << `ECP_M_REL));
        ld(2'h2, 32'(1 << `ECP_M_CONT));
        ld(2'h3, 32'((1 << `ECP_M_CONT) | (1 << `ECP_M_AUTO)));
        // Absolute single shot, offset 0 and MAXIN
        for (int o = 0; o < 2; o++) begin
            axw(`ECP_A_OFFS, 32'(o * MAXIN));
            run(2'h0);
            cmpv(fpos, 32'h0000_0000, "abs start");
            k = $urandom_range(29, 1);
            mv(32 * k);
            cmpv(fpos, cam(32 * k, o * MAXIN), "interp");
        end
        axw(`ECP_A_OFFS, 32'h0000_0000);
        mv(MAXIN);
        cmpv({31'h0, running}, 32'h0000_0000, "shot end");
        cmpv(fpos, 32'(15 * STEP), "end position");
        cmpv({30'h0, atab}, 32'h0000_0000, "table kept");
        mv(64);
        cmpv({31'h0, running}, 32'h0000_0000, "no rerun");
        cmpv(fpos, 32'(15 * STEP), "end held");
        $display("absolute done");
        // Relative start
        v = $urandom_range(100000, 0);
        ecp_pos_chain_inst.set_meas(v);
        run(2'h1);
        cmpv({30'h0, atab}, 32'h0000_0001, "sel table");
        mv(32);
        cmpv(fpos, v + 32'd50, "rel out");
        $display("relative done");
        // Continuous, then stop at max
        run(2'h2);
        mv(MAXIN);
        cmpv({31'h0, running}, 32'h0000_0001, "repeats");
        cmpv({30'h0, atab}, 32'h0000_0002, "no auto");
        mv(MAXIN + 32);
        cmpv(fpos, 32'd50, "second pass");
        ctl(1'b1, 1'b0, 2'h2);
        mv(2 * MAXIN);
        cmpv({31'h0, running}, 32'h0000_0000, "stop at max");
        $display("continuous done");
        // Auto increment wrap and back step
        run(2'h3);
        mv(MAXIN);
        cmpv({30'h0, atab}, 32'h0000_0000, "wrap");
        run(2'h3);
        mv(-16);
        cmpv({30'h0, atab}, 32'h0000_0002, "step back");
        // Single shot auto, mode from table
        axw(`ECP_A_TAB + 12'h004, 32'(1 << `ECP_M_AUTO));
        run(2'h0);
        mv(MAXIN);
        cmpv({30'h0, atab}, 32'h0000_0000, "kept at end");
        run(2'h0);
        cmpv({30'h0, atab}, 32'h0000_0001, "next table");
        $display("auto done");
        summarize();
    end
endmodule // ecp_cam_profiler_bench

//--- testbench/ecp_pos_chain.sv
`timescale 1ns/1ns
module ecp_pos_chain (
    // Clock
    input wire logic i_mclk,
    // Reference from the profiler
    input wire logic [31:0] i_follower_pos,
    // Master and measured positions
    output logic [31:0] o_master_pos,
    output logic [31:0] o_measured_position
);
    logic [31:0] meas_set_ff = 32'h0000_0000;
    logic track_ff = 1'b1;
    initial o_master_pos = 32'h0000_0000;
    initial o_measured_position = 32'h0000_0000;
    // Called just after an edge
    task automatic set_master(input logic [31:0] v);
        o_master_pos <= v;
    endtask
    // A forced value stops tracking
    task automatic set_meas(input logic [31:0] v);
        meas_set_ff <= v;
        track_ff <= 1'b0;
    endtask
    // Measured trails the reference a clock
    always @(posedge i_mclk) begin
        o_measured_position <= track_ff ? i_follower_pos : meas_set_ff;
    end
endmodule // ecp_pos_chain
